// file: msc_pkg.sv
// Shared constants and types for the Manchester sync status block
package msc_pkg;
  localparam int          DEC_NUM        = 3;
  localparam int          ADDR_W         = 8;
  localparam int          DATA_W         = 16;
  localparam int          STAT_W         = 8;
  localparam logic [7:0]  ADDR_RESULT    = 8'h12;
  localparam logic [7:0]  ADDR_STATUS    = 8'h13;
  localparam logic [7:0]  STATUS_RST     = 8'h30;
  localparam logic [15:0] RESULT_RST     = 16'h0000;
  localparam int          SYNC_LSB       = 0;
  localparam int          SEL_LSB        = 4;
  localparam int          SEL_MSB        = 5;
  localparam int          RSV3_BIT       = 3;
  localparam logic [1:0]  SEL_DEC0       = 2'h0;
  localparam logic [1:0]  SEL_DEC1       = 2'h1;
  localparam logic [1:0]  SEL_DEC2       = 2'h2;
  localparam logic [1:0]  SEL_OFF        = 2'h3;
  localparam logic [1:0]  SYNC_ERR_LIMIT = 2'h3;
  localparam logic [3:0]  FRAME_SPAN     = 4'hA;
  localparam int          MEAS_EXP       = 9;
  localparam int          MEAS_TICKS     = 2 ** MEAS_EXP;
  localparam int          TICK_W         = MEAS_EXP + 1;
  localparam logic        CORE_SUP       = 1'b0;
  localparam logic        CORE_PROC      = 1'b1;

  typedef enum logic [1:0] {
    MEAS_IDLE = 2'b01,
    MEAS_RUN  = 2'b10
  } msc_meas_e;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
    logic              core;
  } msc_bus_s;

  typedef struct packed {
    logic acquire;
    logic lost;
    logic sync_err;
    logic frame;
    logic sync_bit;
  } msc_dec_ev_s;
endpackage : msc_pkg

// file: msc_pin_sync.sv
// Three-stage pin synchroniser with agreement filter and rise pulse
module msc_pin_sync (
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic pin,
  output logic      rise
);
  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic lvl_q;

  // Reset high so a pin already high at release gives no false rise
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
      s3_q <= 1'b1;
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Only a level seen on two stages counts, so one glitch is ignored
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      lvl_q <= 1'b1;
    end else if (s2_q == s3_q) begin
      lvl_q <= s3_q;
    end
  end

  assign rise = (s2_q == s3_q) && s3_q && !lvl_q;
endmodule // msc_pin_sync

// file: msc_sync_track.sv
// Per-decoder sync flag with sync-bit-error loss window
module msc_sync_track #(
  parameter bit LOSS_EN = 1'b1
) (
  input  wire logic                 mclk,
  input  wire logic                 rst,
  input  wire msc_pkg::msc_dec_ev_s ev,
  output logic                      sync_q
);
  logic [1:0] err_cnt_q;
  logic [3:0] frm_cnt_q;
  logic       win_q;
  logic       err_hit;
  logic       win_end;
  logic       loss;

  assign err_hit = sync_q && ev.sync_err;
  assign win_end = win_q && ev.frame && (frm_cnt_q == msc_pkg::FRAME_SPAN - 4'h1);
  assign loss    = LOSS_EN && err_hit && win_q && !win_end
                   && (err_cnt_q == msc_pkg::SYNC_ERR_LIMIT - 2'h1);

  // Acquire wins over any clear in the same cycle
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sync_q <= 1'b0;
    end else if (ev.acquire) begin
      sync_q <= 1'b1; // [RULE3]
    end else if (ev.lost || loss) begin
      sync_q <= 1'b0; // [RULE4] [RULE5]
    end
  end

  // Window opens on an error; a closed window forgets its errors
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      err_cnt_q <= 2'h0;
      frm_cnt_q <= 4'h0;
      win_q     <= 1'b0;
    end else if (!sync_q || loss) begin
      err_cnt_q <= 2'h0;
      frm_cnt_q <= 4'h0;
      win_q     <= 1'b0;
    end else if (err_hit && (!win_q || win_end)) begin
      err_cnt_q <= 2'h1; // [RULE6]
      frm_cnt_q <= 4'h0;
      win_q     <= 1'b1;
    end else if (win_end) begin
      err_cnt_q <= 2'h0; // [RULE6]
      frm_cnt_q <= 4'h0;
      win_q     <= 1'b0;
    end else begin
      if (err_hit) begin
        err_cnt_q <= err_cnt_q + 2'h1;
      end
      if (win_q && ev.frame) begin
        frm_cnt_q <= frm_cnt_q + 4'h1;
      end
    end
  end

  a_acquire_sets: assert property ( // [RULE3]
    @(posedge mclk) disable iff (rst) ev.acquire |=> sync_q)
    else $error("sync flag not set after acquire");

  a_lost_clears: assert property ( // [RULE4]
    @(posedge mclk) disable iff (rst) (ev.lost && !ev.acquire) |=> !sync_q)
    else $error("sync flag still set while unsynchronised");

  a_third_error_loss: assert property ( // [RULE5]
    @(posedge mclk) disable iff (rst)
    (LOSS_EN && loss && !ev.acquire) |=> !sync_q)
    else $error("third error in span did not drop sync");

  a_span_restart: assert property ( // [RULE6]
    @(posedge mclk) disable iff (rst)
    (win_end && !err_hit && sync_q) |=> (err_cnt_q == 2'h0) && !win_q)
    else $error("error count carried past span");
endmodule // msc_sync_track

// file: msc_status_ctrl.sv
// Manchester status register, sync tracking and clock measurement control
// Contract
// [RULE1] Status register resets to 30h.
// [RULE2] Status always readable; only bits 5:4 accept writes.
// [RULE3] Decoder sync flag sets when that decoder achieves synchronization.
// [RULE4] Sync flag reads 0 while the decoder lacks the alternating sync bit.
// [RULE5] Decoders 0 and 1 lose sync after three sync bit errors in 10 frames.
// [RULE6] Fewer than three errors in a span: counting restarts at next error.
// [RULE7] Status bit 3 reads 0.
// [RULE8] Active selector at 11b keeps measurement disabled.
// [RULE9] Writing active selector with non-11b starts one measurement interval.
// [RULE10] Measurement start clears result to 0000h, busy until written.
// [RULE11] Two separate selector copies, one per core.
// [RULE12] Core-select 0 uses supervisory copy, 1 uses processing copy.
// [RULE13] Inactive copy stays writable but does not touch the measurement.
// [RULE14] Software avoids a second request while one is outstanding; polls busy.
// [RULE15] No hardware interlock against conflicting requests.
// [RULE16] Count sync bits over 2^9 ticks of 32kHz, then write result.
// [RULE17] Status bits 7:6 read 0.
// [RULE18] Selector 00b, 01b, 10b pick decoders 0..2; 11b disables.
//
// Local design decision: the strobed register port.
module msc_status_ctrl #(
  parameter int MEAS_TICKS = msc_pkg::MEAS_TICKS
) (
  input  wire logic                                  mclk,
  input  wire logic                                  rst,
  input  wire msc_pkg::msc_bus_s                     bus,
  output logic [msc_pkg::DATA_W-1:0]                 rdata_q,
  input  wire msc_pkg::msc_dec_ev_s [msc_pkg::DEC_NUM-1:0] dec_ev,
  input  wire logic                                  processing_core_select,
  input  wire logic                                  clk_32k_pin,
  output logic [msc_pkg::DEC_NUM-1:0]                sync_flags,
  output logic                                       meas_busy
);
  localparam int TW = msc_pkg::TICK_W;
  localparam logic [TW-1:0] TICK_LAST = TW'(MEAS_TICKS - 1);

  logic [1:0]                   sel_sup_q;
  logic [1:0]                   sel_proc_q;
  logic [1:0]                   active_sel;
  logic [msc_pkg::DATA_W-1:0]   result_q;
  logic [msc_pkg::DATA_W-1:0]   bit_cnt_q;
  logic [TW-1:0]                tick_cnt_q;
  msc_pkg::msc_meas_e           state_q;
  logic                         tick_rise;
  logic                         stat_wr;
  logic                         stat_rd;
  logic                         res_rd;
  logic                         start;
  logic                         stop;
  logic                         win_done;
  logic                         sel_bit;
  logic [msc_pkg::STAT_W-1:0]   stat_val;
  logic [1:0]                   own_sel;

  // Decode an address against one register
  function automatic logic hit(input logic [msc_pkg::ADDR_W-1:0] a,
                               input logic [msc_pkg::ADDR_W-1:0] r);
    hit = (a == r);
  endfunction

  // Which decoder's sync bit a selector names
  function automatic logic pick_bit(input logic [1:0] s,
                                    input msc_pkg::msc_dec_ev_s [msc_pkg::DEC_NUM-1:0] e);
    case (s)
      msc_pkg::SEL_DEC0: pick_bit = e[0].sync_bit; // [RULE18]
      msc_pkg::SEL_DEC1: pick_bit = e[1].sync_bit; // [RULE18]
      msc_pkg::SEL_DEC2: pick_bit = e[2].sync_bit; // [RULE18]
      default:           pick_bit = 1'b0;
    endcase
  endfunction

  assign stat_wr = bus.wr && hit(bus.addr, msc_pkg::ADDR_STATUS);
  assign stat_rd = bus.rd && hit(bus.addr, msc_pkg::ADDR_STATUS);
  assign res_rd  = bus.rd && hit(bus.addr, msc_pkg::ADDR_RESULT);

  msc_pin_sync u_tick (
    .mclk (mclk),
    .rst  (rst),
    .pin  (clk_32k_pin),
    .rise (tick_rise)
  );

  // Decoder 2 has no error-driven loss of sync
  genvar gi;
  generate
    for (gi = 0; gi < msc_pkg::DEC_NUM; gi++) begin : g_dec
      msc_sync_track #(
        .LOSS_EN (gi < 2)
      ) u_track (
        .mclk   (mclk),
        .rst    (rst),
        .ev     (dec_ev[gi]),
        .sync_q (sync_flags[gi])
      );
    end
  endgenerate

  // One selector copy per core, each written only by its own core
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sel_sup_q <= msc_pkg::STATUS_RST[msc_pkg::SEL_MSB:msc_pkg::SEL_LSB]; // [RULE1]
    end else if (stat_wr && bus.core == msc_pkg::CORE_SUP) begin
      sel_sup_q <= bus.wdata[msc_pkg::SEL_MSB:msc_pkg::SEL_LSB]; // [RULE11] [RULE2]
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sel_proc_q <= msc_pkg::STATUS_RST[msc_pkg::SEL_MSB:msc_pkg::SEL_LSB]; // [RULE1]
    end else if (stat_wr && bus.core == msc_pkg::CORE_PROC) begin
      sel_proc_q <= bus.wdata[msc_pkg::SEL_MSB:msc_pkg::SEL_LSB]; // [RULE11] [RULE2]
    end
  end

  // Core-select steers which copy reaches the hardware
  assign active_sel = processing_core_select ? sel_proc_q : sel_sup_q; // [RULE12]

  // Only the active core's write can start; a repeat restarts, no lockout
  assign start = stat_wr && (bus.core == processing_core_select) // [RULE13] [RULE15]
                 && (bus.wdata[msc_pkg::SEL_MSB:msc_pkg::SEL_LSB] != msc_pkg::SEL_OFF); // [RULE9]
  assign stop  = (active_sel == msc_pkg::SEL_OFF) && !start; // [RULE8]

  assign win_done = (state_q == msc_pkg::MEAS_RUN) && tick_rise
                    && (tick_cnt_q == TICK_LAST);
  assign sel_bit  = pick_bit(active_sel, dec_ev);
  assign meas_busy = (state_q == msc_pkg::MEAS_RUN);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_q <= msc_pkg::MEAS_IDLE;
    end else begin
      case (state_q)
        msc_pkg::MEAS_IDLE: begin
          if (start) begin
            state_q <= msc_pkg::MEAS_RUN; // [RULE9]
          end
        end
        msc_pkg::MEAS_RUN: begin
          // A restart on the final tick must not end the fresh run
          if (!start && (stop || win_done)) begin
            state_q <= msc_pkg::MEAS_IDLE; // [RULE8] [RULE16]
          end
        end
        default: state_q <= msc_pkg::MEAS_IDLE;
      endcase
    end
  end

  // Window length counted in filtered 32kHz rises, not system cycles
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      tick_cnt_q <= '0;
    end else if (start) begin
      tick_cnt_q <= '0;
    end else if (meas_busy && tick_rise) begin
      tick_cnt_q <= tick_cnt_q + TW'(1); // [RULE16]
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      bit_cnt_q <= msc_pkg::RESULT_RST;
    end else if (start) begin
      bit_cnt_q <= msc_pkg::RESULT_RST;
    end else if (meas_busy && sel_bit) begin
      bit_cnt_q <= bit_cnt_q + msc_pkg::DATA_W'(1); // [RULE16]
    end
  end

  // Result reads zero as the busy mark; a last sync bit on the final tick counts
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      result_q <= msc_pkg::RESULT_RST;
    end else if (start) begin
      result_q <= msc_pkg::RESULT_RST; // [RULE10]
    end else if (win_done && !stop) begin
      result_q <= bit_cnt_q + msc_pkg::DATA_W'(sel_bit); // [RULE16]
    end
  end

  // Each core sees its own selector copy in bits 5:4
  assign own_sel = bus.core ? sel_proc_q : sel_sup_q;

  always_comb begin
    stat_val = '0; // [RULE7] [RULE17]
    stat_val[msc_pkg::SEL_MSB:msc_pkg::SEL_LSB] = own_sel;
    stat_val[msc_pkg::SYNC_LSB +: msc_pkg::DEC_NUM] = sync_flags; // [RULE3]
  end

  // Reads answer in the next cycle; unmapped addresses read zero
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rdata_q <= '0;
    end else if (stat_rd) begin
      rdata_q <= msc_pkg::DATA_W'(stat_val); // [RULE2]
    end else if (res_rd) begin
      rdata_q <= result_q;
    end else begin
      rdata_q <= '0;
    end
  end

  a_reset_value: assert property ( // [RULE1]
    @(posedge mclk) rst |-> (stat_val == msc_pkg::STATUS_RST))
    else $error("status not at reset value");

  a_reserved_zero: assert property ( // [RULE7] [RULE17]
    @(posedge mclk) disable iff (rst)
    stat_rd |=> (rdata_q[7:6] == 2'h0) && (rdata_q[msc_pkg::RSV3_BIT] == 1'b0))
    else $error("reserved status bits not zero");

  a_sync_readonly: assert property ( // [RULE2]
    @(posedge mclk) disable iff (rst)
    (stat_wr && !dec_ev[0].acquire && !dec_ev[0].lost && !dec_ev[0].sync_err)
    |=> sync_flags[0] == $past(sync_flags[0]))
    else $error("write altered a sync flag");

  a_sel_disabled: assert property ( // [RULE8]
    @(posedge mclk) disable iff (rst)
    (active_sel == msc_pkg::SEL_OFF && !start) |=> !meas_busy)
    else $error("measurement runs while disabled");

  a_start_clears: assert property ( // [RULE9] [RULE10]
    @(posedge mclk) disable iff (rst)
    start |=> meas_busy && (result_q == msc_pkg::RESULT_RST) ##1 (result_q == msc_pkg::RESULT_RST))
    else $error("start did not clear result and run");

  a_inactive_copy: assert property ( // [RULE13]
    @(posedge mclk) disable iff (rst)
    (stat_wr && bus.core != processing_core_select && !meas_busy) |=> !meas_busy)
    else $error("inactive copy started a measurement");

  a_route_copy: assert property ( // [RULE12]
    @(posedge mclk) disable iff (rst)
    (stat_wr && bus.core == processing_core_select)
    |=> active_sel == $past(bus.wdata[msc_pkg::SEL_MSB:msc_pkg::SEL_LSB]))
    else $error("active copy not steering hardware");

  a_result_written: assert property ( // [RULE16]
    @(posedge mclk) disable iff (rst)
    (win_done && !stop && !start)
    |=> !meas_busy && (result_q == $past(bit_cnt_q) + msc_pkg::DATA_W'($past(sel_bit))))
    else $error("result not written at window end");
endmodule // msc_status_ctrl

// file: msc_mod_model.sv
// Behavioural modulator side: 32 kHz reference and decoder event streams
module msc_mod_model (
  input  wire logic                                        mclk,
  input  wire logic                                        rst,
  input  wire msc_pkg::msc_dec_ev_s [msc_pkg::DEC_NUM-1:0] cmd,
  output msc_pkg::msc_dec_ev_s [msc_pkg::DEC_NUM-1:0]      dec_ev,
  output logic                                             clk_32k_pin
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [5:0]                  ph_q;
  logic [msc_pkg::DEC_NUM-1:0] sb_q;

  // Reference scaled to 64 mclk per period so runs stay short
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ph_q <= 6'h00;
    end else begin
      ph_q <= ph_q + 6'h01;
    end
  end

  // Free-running oscillator, so no idle level between windows
  assign clk_32k_pin = ~ph_q[5];

  // Decoder d sends d+1 sync bits per period, kept clear of the rise
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sb_q <= 3'h0;
    end else begin
      sb_q[0] <= (ph_q == 6'h10);
      sb_q[1] <= (ph_q == 6'h10) || (ph_q == 6'h20);
      sb_q[2] <= (ph_q == 6'h10) || (ph_q == 6'h20) || (ph_q == 6'h30);
    end
  end

  always_comb begin
    for (int i = 0; i < msc_pkg::DEC_NUM; i++) begin
      dec_ev[i]          = cmd[i];
      dec_ev[i].sync_bit = cmd[i].sync_bit | sb_q[i];
    end
  end
endmodule // msc_mod_model

// file: tb.sv
// Self-checking bench for the Manchester status and measurement block
module tb;
  timeunit 1ns;
  timeprecision 1ps;

  localparam msc_pkg::msc_dec_ev_s EV_ACQ  = 5'h10;
  localparam msc_pkg::msc_dec_ev_s EV_LOST = 5'h08;
  localparam msc_pkg::msc_dec_ev_s EV_ERR  = 5'h04;
  localparam msc_pkg::msc_dec_ev_s EV_FRM  = 5'h02;

  logic                             mclk        = 1'b0;
  logic                             rst         = 1'b0;
  msc_pkg::msc_bus_s                bus         = '0;
  msc_pkg::msc_dec_ev_s [2:0]       cmd         = '0;
  msc_pkg::msc_dec_ev_s [2:0]       dec_ev;
  logic                             pcs         = 1'b0;
  logic [15:0]                      rdata_q;
  logic                             clk_32k_pin;
  logic [2:0]                       sync_flags;
  logic                             meas_busy;
  logic [15:0]                      rd_val;
  int                               error_cnt   = 0;
  int                               comparisons = 0;

  always #10 mclk = ~mclk;

  msc_status_ctrl #(.MEAS_TICKS(4)) uut (
    .mclk(mclk), .rst(rst), .bus(bus), .rdata_q(rdata_q), .dec_ev(dec_ev),
    .processing_core_select(pcs), .clk_32k_pin(clk_32k_pin),
    .sync_flags(sync_flags), .meas_busy(meas_busy));

  msc_mod_model model (
    .mclk(mclk), .rst(rst), .cmd(cmd), .dec_ev(dec_ev), .clk_32k_pin(clk_32k_pin));

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic bus_wr(input logic core, input logic [7:0] a, input logic [15:0] d);
    @(posedge mclk);
    bus.addr  <= a;
    bus.wdata <= d;
    bus.core  <= core;
    bus.wr    <= 1'b1;
    @(posedge mclk);
    bus.wr <= 1'b0;
  endtask

  task automatic bus_rd(input logic core, input logic [7:0] a);
    @(posedge mclk);
    bus.addr <= a;
    bus.core <= core;
    bus.rd   <= 1'b1;
    @(posedge mclk);
    bus.rd <= 1'b0;
    #1;
    rd_val = rdata_q;
  endtask

  task automatic ev(input int d, input msc_pkg::msc_dec_ev_s k);
    @(posedge mclk);
    cmd[d] <= k;
    @(posedge mclk);
    cmd[d] <= '0;
    #1;
  endtask

  task automatic flags(input logic [2:0] exp);
    repeat (2) @(posedge mclk);
    #1;
    check("sync_flags", {13'h0000, sync_flags}, {13'h0000, exp});
  endtask

  task automatic t_reset;
    bus_rd(1'b0, msc_pkg::ADDR_STATUS);
    check("status", rd_val, 16'h0030);
    bus_wr(1'b0, msc_pkg::ADDR_RESULT, 16'hBEEF);
    bus_rd(1'b0, msc_pkg::ADDR_RESULT);
    check("result", rd_val, 16'h0000);
    bus_rd(1'b0, 8'h55);
    check("unmapped", rd_val, 16'h0000);
    check("flags", {13'h0000, sync_flags}, 16'h0000);
  endtask

  task automatic t_mask;
    bus_wr(1'b0, msc_pkg::ADDR_STATUS, 16'h00FF);
    bus_rd(1'b0, msc_pkg::ADDR_STATUS);
    check("status", rd_val, 16'h0030);
    check("busy", {15'h0000, meas_busy}, 16'h0000);
    bus_wr(1'b0, msc_pkg::ADDR_STATUS, 16'hFFCF);
    #1;
    check("busy", {15'h0000, meas_busy}, 16'h0001);
    bus_rd(1'b0, msc_pkg::ADDR_STATUS);
    check("status", rd_val, 16'h0000);
    // Disable request in mid-run must stop the interval
    bus_wr(1'b0, msc_pkg::ADDR_STATUS, 16'h0030);
    repeat (2) @(posedge mclk);
    #1;
    check("busy", {15'h0000, meas_busy}, 16'h0000);
    bus_rd(1'b0, msc_pkg::ADDR_RESULT);
    check("result", rd_val, 16'h0000);
  endtask

  // Start just after a reference rise so the count is exact
  task automatic meas(input logic core, input logic [1:0] sel, input logic [15:0] exp);
    int n;
    n = 0;
    @(posedge clk_32k_pin);
    repeat (8) @(posedge mclk);
    bus_wr(core, msc_pkg::ADDR_STATUS, {10'h000, sel, 4'hF});
    #1;
    check("busy", {15'h0000, meas_busy}, 16'h0001);
    bus_rd(core, msc_pkg::ADDR_RESULT);
    check("result", rd_val, 16'h0000);
    // No second request until the run is over
    while (meas_busy === 1'b1 && n < 2000) begin
      @(posedge mclk);
      #1;
      n++;
    end
    check("done", {15'h0000, meas_busy}, 16'h0000);
    bus_rd(core, msc_pkg::ADDR_RESULT);
    check("result", rd_val, exp);
    repeat (300) @(posedge mclk);
    #1;
    check("busy", {15'h0000, meas_busy}, 16'h0000);
  endtask

  task automatic t_core;
    @(posedge mclk);
    pcs <= 1'b1;
    bus_wr(1'b0, msc_pkg::ADDR_STATUS, 16'h0000);
    #1;
    check("busy", {15'h0000, meas_busy}, 16'h0000);
    bus_rd(1'b0, msc_pkg::ADDR_RESULT);
    check("result", rd_val, 16'h000C);
    meas(1'b1, 2'h1, 16'h0008);
    bus_rd(1'b0, msc_pkg::ADDR_STATUS);
    check("status", rd_val, 16'h0000);
    bus_rd(1'b1, msc_pkg::ADDR_STATUS);
    check("status", rd_val, 16'h0010);
    @(posedge mclk);
    pcs <= 1'b0;
  endtask

  task automatic t_sync;
    for (int d = 0; d < 3; d++) ev(d, EV_ACQ);
    flags(3'h7);
    bus_rd(1'b0, msc_pkg::ADDR_STATUS);
    // Supervisory copy was left at 00b by the core scenario
    check("status", rd_val, 16'h0007);
    repeat (3) ev(0, EV_ERR);
    flags(3'h6);
    repeat (3) ev(2, EV_ERR);
    flags(3'h6);
    repeat (2) ev(1, EV_ERR);
    repeat (10) ev(1, EV_FRM);
    ev(1, EV_ERR);
    flags(3'h6);
    repeat (2) ev(1, EV_ERR);
    flags(3'h4);
    ev(2, EV_LOST);
    flags(3'h0);
  endtask

  task automatic print_verdict;
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    // Rising reset edge at time zero loads every register before the first clock
    rst <= 1'b1;
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    t_reset;
    t_mask;
    for (int d = 0; d < 3; d++) meas(1'b0, 2'(d), 16'(4 * (d + 1)));
    t_core;
    t_sync;
    print_verdict;
  end

  // Whole run is near 2500 cycles; this allows well over three times that
  initial begin
    #400000;
    error_cnt++;
    print_verdict;
  end
endmodule // tb
